/* design/tmss_pkg.sv */
// package for the track monitor source select block
// Contract
// - override routes source to every track
// - override lights its lamp and all track lamps
// - release restores previous per-track select state
// - per-track presses ignored while override on
// - auto+armed outside shuttle: play tape, else source
// - other cases switch selects; tape needs motion
// - auto off, armed, record: source unless verify
// - auto off: shuttle setting ignored, switch selects
// - auto+shuttle mon: armed tracks source in shuttle
// - auto, shuttle mon off: armed tracks tape
// - unarmed track switch toggles selection unless override on
// - override beats shuttle monitoring choices
// - shuttle output attenuated by 12 dB
// - shuttle silence disables shuttle output
// - any track may feed any output channel
// - routing altered lamp when patch not identity
package tmss_pkg;
   localparam int          TRACKS      = 8;
   localparam int          SAMPLE_W    = 24;
   localparam int          IDX_W       = 3;
   localparam int          ATTEN_DB    = 12;
   localparam int          ATTEN_SHIFT = ATTEN_DB / 6;
   // wishbone map
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_STATUS  = 8'h04;
   localparam logic [7:0]  REG_PATCH   = 8'h08;
   localparam logic [7:0]  REG_TSEL    = 8'h0c;
   localparam int          CTRL_OVR    = 0;
   localparam int          CTRL_AUTO   = 1;
   localparam int          CTRL_SHMON  = 2;
   localparam int          CTRL_SHMUTE = 3;
   localparam int          CTRL_VERIFY = 4;
   localparam logic [31:0] PATCH_RST   = 32'h00fa_c688;
   typedef enum logic [2:0]
   {
      TMSS_STOP    = 3'b000,
      TMSS_PLAY    = 3'b001,
      TMSS_RECORD  = 3'b010,
      TMSS_SHUTTLE = 3'b011
   } tmss_xport_e;
endpackage

/* design/tmss_router.sv */
// track to output channel patch
`timescale 1ns/1ps
module tmss_router
   import tmss_pkg::*;
(
   input  wire logic [TRACKS*SAMPLE_W-1:0] trk_i,
   input  wire logic [TRACKS*IDX_W-1:0]    patch_i,
   output logic      [TRACKS*SAMPLE_W-1:0] out_o,
   output logic                            altered_o
);
   import tmss_pkg::*;
   always_comb
   begin
      altered_o = 1'b0;
      for (int c = 0; c < TRACKS; c++)
      begin
         out_o[c*SAMPLE_W +: SAMPLE_W] = trk_i[patch_i[c*IDX_W +: IDX_W]*SAMPLE_W +: SAMPLE_W];
         if (patch_i[c*IDX_W +: IDX_W] != IDX_W'(c))
            altered_o = 1'b1;
      end
   end
endmodule

/* design/tmss_top.sv */
// track monitor source select top with wishbone registers
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module tmss_top
   import tmss_pkg::*;
(
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic [7:0]                    adr_i,
   input  wire logic [31:0]                   dat_i,
   input  wire logic                          we_i,
   input  wire logic [3:0]                    sel_i,
   input  wire logic                          cyc_i,
   input  wire logic                          stb_i,
   output logic      [31:0]                   dat_o,
   output logic                               ack_o,
   output logic                               err_o,
   input  wire logic [tmss_pkg::TRACKS-1:0]   track_arm_i,
   input  wire logic [tmss_pkg::TRACKS-1:0]   sel_press_i,
   input  wire logic                          ovr_press_i,
   input  wire logic [2:0]                    xport_i,
   input  wire logic [tmss_pkg::TRACKS*tmss_pkg::SAMPLE_W-1:0] src_i,
   input  wire logic [tmss_pkg::TRACKS*tmss_pkg::SAMPLE_W-1:0] tape_i,
   output logic      [tmss_pkg::TRACKS*tmss_pkg::SAMPLE_W-1:0] out_o,
   output logic      [tmss_pkg::TRACKS-1:0]   track_src_o,
   output logic      [tmss_pkg::TRACKS-1:0]   sel_lamp_o,
   output logic                               ovr_lamp_o,
   output logic                               altered_lamp_o
);
   import tmss_pkg::*;
   typedef struct packed
   {
      logic [4:0]              ctrl;
      logic [TRACKS-1:0]       tsel;
      logic [TRACKS*IDX_W-1:0] patch;
      logic                    ack;
      logic                    err;
      logic [31:0]             rdat;
      logic [TRACKS*SAMPLE_W-1:0] outd;
      logic [TRACKS-1:0]       srcd;
   } tmss_state_s;
   tmss_state_s st_r, st_nxt;
   tmss_xport_e xp;
   logic [TRACKS-1:0]          use_src;
   logic [TRACKS*SAMPLE_W-1:0] mon, routed;
   logic                       altered;
   logic                       req, shut;
   assign xp = tmss_xport_e'(xport_i);
   assign shut = (xp == TMSS_SHUTTLE);
   assign req = cyc_i && stb_i && !st_r.ack && !st_r.err;
   for (genvar t = 0; t < TRACKS; t++)
   begin : g_trk
      tmss_track_sel u_sel (
         .ovr_i     (st_r.ctrl[CTRL_OVR]),
         .auto_i    (st_r.ctrl[CTRL_AUTO]),
         .shmon_i   (st_r.ctrl[CTRL_SHMON]),
         .verify_i  (st_r.ctrl[CTRL_VERIFY]),
         .armed_i   (track_arm_i[t]),
         .sel_src_i (st_r.tsel[t]),
         .xport_i   (xp),
         .src_o     (use_src[t])
      );
   end
   function automatic logic [SAMPLE_W-1:0] atten(input logic [SAMPLE_W-1:0] s);
      atten = $signed(s) >>> ATTEN_SHIFT;
   endfunction
   always_comb
   begin
      for (int t = 0; t < TRACKS; t++)
      begin
         mon[t*SAMPLE_W +: SAMPLE_W] = use_src[t] ? src_i[t*SAMPLE_W +: SAMPLE_W]
                                                  : tape_i[t*SAMPLE_W +: SAMPLE_W];
         if (shut && st_r.ctrl[CTRL_SHMUTE])
            mon[t*SAMPLE_W +: SAMPLE_W] = '0;
         else if (shut)
            mon[t*SAMPLE_W +: SAMPLE_W] = atten(mon[t*SAMPLE_W +: SAMPLE_W]);
      end
   end
   tmss_router u_rt (
      .trk_i     (mon),
      .patch_i   (st_r.patch),
      .out_o     (routed),
      .altered_o (altered)
   );
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.err = 1'b0;
      st_nxt.outd = routed;
      st_nxt.srcd = use_src;
      if (!st_r.ctrl[CTRL_OVR])
         st_nxt.tsel = st_r.tsel ^ sel_press_i;
      if (ovr_press_i)
         st_nxt.ctrl[CTRL_OVR] = !st_r.ctrl[CTRL_OVR];
      if (req)
      begin
         st_nxt.rdat = '0;
         unique case (adr_i)
            REG_CTRL:
            begin
               st_nxt.ack = 1'b1;
               st_nxt.rdat = {27'h000_0000, st_r.ctrl};
               if (we_i && sel_i[0])
                  st_nxt.ctrl = dat_i[4:0];
            end
            REG_STATUS:
            begin
               st_nxt.ack = 1'b1;
               st_nxt.rdat = {7'h00, altered, use_src, track_arm_i, 5'h00, xport_i};
            end
            REG_PATCH:
            begin
               st_nxt.ack = 1'b1;
               st_nxt.rdat = {8'h00, st_r.patch};
               if (we_i)
                  for (int b = 0; b < 3; b++)
                     if (sel_i[b])
                        st_nxt.patch[b*8 +: 8] = dat_i[b*8 +: 8];
            end
            REG_TSEL:
            begin
               st_nxt.ack = 1'b1;
               st_nxt.rdat = {24'h00_0000, st_r.tsel};
               if (we_i && sel_i[0] && !st_r.ctrl[CTRL_OVR])
                  st_nxt.tsel = dat_i[7:0];
            end
            default:
               st_nxt.err = 1'b1;
         endcase
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r <= '0;
         st_r.patch <= PATCH_RST[TRACKS*IDX_W-1:0];
      end
      else
         st_r <= st_nxt;
   end
   assign dat_o = st_r.rdat;
   assign ack_o = st_r.ack;
   assign err_o = st_r.err;
   assign out_o = st_r.outd;
   assign track_src_o = st_r.srcd;
   assign ovr_lamp_o = st_r.ctrl[CTRL_OVR];
   assign sel_lamp_o = st_r.ctrl[CTRL_OVR] ? '1 : st_r.tsel;
   assign altered_lamp_o = altered;

   ovr_forces_a: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.ctrl[CTRL_OVR] |-> ##1 (&track_src_o)) else $error("override not source");
   lamps_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ovr_lamp_o |-> (&sel_lamp_o)) else $error("override lamps wrong");
   sequence ovr_span;
      !st_r.ctrl[CTRL_OVR] ##1 st_r.ctrl[CTRL_OVR] && !req;
   endsequence
   keep_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ovr_span |-> $stable(st_r.tsel)) else $error("select lost under override");
   auto_play_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!st_r.ctrl[CTRL_OVR] && st_r.ctrl[CTRL_AUTO] && xp == TMSS_PLAY && track_arm_i[0])
      |-> !use_src[0]) else $error("auto play not tape");
   still_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (xp == TMSS_STOP) |-> (&use_src)) else $error("tape while stopped");
   rec_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!st_r.ctrl[CTRL_AUTO] && !st_r.ctrl[CTRL_VERIFY] && xp == TMSS_RECORD && track_arm_i[0])
      |-> use_src[0]) else $error("armed record not source");
   shut_mon_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!st_r.ctrl[CTRL_OVR] && st_r.ctrl[CTRL_AUTO] && shut && track_arm_i[0])
      |-> use_src[0] == st_r.ctrl[CTRL_SHMON]) else $error("shuttle choice wrong");
   free_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!st_r.ctrl[CTRL_OVR] && !track_arm_i[0] && xp == TMSS_PLAY) |-> use_src[0] == st_r.tsel[0])
      else $error("unarmed select ignored");
   mute_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (shut && st_r.ctrl[CTRL_SHMUTE]) |-> ##1 (out_o == '0)) else $error("shuttle not muted");
   patch_lamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_r.patch == PATCH_RST[TRACKS*IDX_W-1:0]) |-> !altered_lamp_o) else $error("lamp on identity");
   // registered source flags follow the decision by one cycle, skipping the reset cycle
   src_lag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> track_src_o == $past(use_src)) else $error("source flags not one cycle behind");
   press_tog_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!st_r.ctrl[CTRL_OVR] && !req) |=> st_r.tsel == ($past(st_r.tsel) ^ $past(sel_press_i)))
      else $error("select press not toggled");
   ovr_tog_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ovr_press_i && !req) |=> st_r.ctrl[CTRL_OVR] != $past(st_r.ctrl[CTRL_OVR]))
      else $error("override press not toggled");
   ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o) else $error("ack longer than one cycle");
   bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req |=> (ack_o != err_o)) else $error("bus request not answered once");
endmodule

/* design/tmss_track_sel.sv */
// one track's monitor source decision
`timescale 1ns/1ps
module tmss_track_sel
   import tmss_pkg::*;
(
   input  wire logic        ovr_i,
   input  wire logic        auto_i,
   input  wire logic        shmon_i,
   input  wire logic        verify_i,
   input  wire logic        armed_i,
   input  wire logic        sel_src_i,
   input  tmss_xport_e      xport_i,
   output logic             src_o
);
   import tmss_pkg::*;
   logic moving;
   always_comb
   begin
      moving = (xport_i == TMSS_PLAY) || (xport_i == TMSS_RECORD);
      if (ovr_i)
         src_o = 1'b1;
      else if (xport_i == TMSS_SHUTTLE)
      begin
         if (auto_i && armed_i)
            src_o = shmon_i;
         else
            src_o = sel_src_i;
      end
      else if (auto_i && armed_i)
         src_o = (xport_i != TMSS_PLAY);
      else if (!auto_i && armed_i && xport_i == TMSS_RECORD && !verify_i)
         src_o = 1'b1;
      else
         src_o = sel_src_i || !moving;
   end
endmodule

/* sim/tb.sv */
// testbench for the track monitor source select block
`timescale 1ns/1ps
module tb;
   import tmss_pkg::*;
   logic                         clk_i = 1'b0;
   logic                         rst_i = 1'b1;
   logic [7:0]                   adr_i = '0;
   logic [31:0]                  dat_i = '0;
   logic [3:0]                   sel_i = 4'hf;
   logic                         we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
   logic [31:0]                  dat_o, patch = PATCH_RST;
   logic                         ack_o, err_o, ovr_press_i, ovr_lamp_o, altered_lamp_o;
   logic [TRACKS-1:0]            track_arm_i, sel_press_i, track_src_o, sel_lamp_o;
   logic [TRACKS-1:0]            tsel = '0;
   logic [2:0]                   xport_i;
   logic [4:0]                   ctl = '0;
   logic [TRACKS*SAMPLE_W-1:0]   src_i, tape_i, out_o;
   int                           n_mismatch = 0, total_checks = 0;
   always #2 clk_i = ~clk_i;
   tmss_panel tmss_panel_i (.clk_i(clk_i), .track_arm_o(track_arm_i), .sel_press_o(sel_press_i),
      .ovr_press_o(ovr_press_i), .xport_o(xport_i), .src_o(src_i), .tape_o(tape_i));
   tmss_top tmss_top_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i),
      .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
      .track_arm_i(track_arm_i), .sel_press_i(sel_press_i), .ovr_press_i(ovr_press_i),
      .xport_i(xport_i), .src_i(src_i), .tape_i(tape_i), .out_o(out_o), .track_src_o(track_src_o),
      .sel_lamp_o(sel_lamp_o), .ovr_lamp_o(ovr_lamp_o), .altered_lamp_o(altered_lamp_o));
   task automatic close_out;
      if (n_mismatch == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [191:0] seen, input logic [191:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // classic wishbone single cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      for (n = 0; n < 50 && ack_o !== 1'b1 && err_o !== 1'b1; n++)
         @(posedge clk_i);
      if (n == 50)
      begin
         n_mismatch++;
         close_out();
      end
      q = dat_o;
      e = err_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   function automatic logic e_src(int t);
      if (ctl[CTRL_OVR])
         return 1'b1;
      if (xport_i == 3'h3)
         return (ctl[CTRL_AUTO] && track_arm_i[t]) ? ctl[CTRL_SHMON] : tsel[t];
      if (ctl[CTRL_AUTO] && track_arm_i[t])
         return xport_i != 3'h1;
      if (track_arm_i[t] && xport_i == 3'h2 && !ctl[CTRL_VERIFY])
         return 1'b1;
      return (xport_i == 3'h1 || xport_i == 3'h2) ? tsel[t] : 1'b1;
   endfunction
   function automatic logic [SAMPLE_W-1:0] e_out(int c);
      int                  t;
      logic [SAMPLE_W-1:0] s;
      t = int'(patch[c*3+:3]);
      s = e_src(t) ? src_i[t*SAMPLE_W+:SAMPLE_W] : tape_i[t*SAMPLE_W+:SAMPLE_W];
      if (xport_i == 3'h3 && ctl[CTRL_SHMUTE])
         s = '0;
      else if (xport_i == 3'h3)
         s = $signed(s) >>> ATTEN_SHIFT;
      return s;
   endfunction
   task automatic look;
      logic [TRACKS-1:0]          es;
      logic [TRACKS*SAMPLE_W-1:0] eo;
      logic [31:0]                q;
      logic                       e;
      repeat (3) @(posedge clk_i);
      #1;
      for (int t = 0; t < TRACKS; t++)
      begin
         es[t] = e_src(t);
         eo[t*SAMPLE_W+:SAMPLE_W] = e_out(t);
      end
      chk("track source", track_src_o, es);
      chk("routed output", out_o, eo);
      chk("select lamps", sel_lamp_o, ctl[CTRL_OVR] ? {TRACKS{1'b1}} : tsel);
      chk("override lamp", ovr_lamp_o, ctl[CTRL_OVR]);
      wb(1'b0, REG_STATUS, '0, q, e);
      chk("status", q, {7'h0, patch !== PATCH_RST, es, track_arm_i, 5'h0, xport_i});
   endtask
   initial
   begin
      logic [31:0] q;
      logic        e;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, REG_CTRL, '0, q, e);
      chk("ctrl reset", q, '0);
      wb(1'b0, REG_PATCH, '0, q, e);
      chk("patch reset", q, PATCH_RST);
      wb(1'b0, REG_TSEL, '0, q, e);
      chk("select reset", q, '0);
      wb(1'b0, 8'h10, '0, q, e);
      chk("unmapped error", e, 1'b1);
      tsel = 8'h55;
      wb(1'b1, REG_TSEL, 32'(tsel), q, e);
      // every mode combination except override under every transport state
      for (int m = 0; m < 80; m++)
      begin
         ctl = 5'((m % 16) * 2);
         tmss_panel_i.set(8'h0f, 3'(m / 16));
         wb(1'b1, REG_CTRL, 32'(ctl), q, e);
         look();
      end
      tmss_panel_i.set(8'h0f, 3'h3);
      ctl = 5'h02;
      wb(1'b1, REG_CTRL, 32'(ctl), q, e);
      tmss_panel_i.press('0, 1'b1);
      ctl = 5'h03;
      look();
      tmss_panel_i.press(8'hff, 1'b0);
      wb(1'b1, REG_TSEL, '0, q, e);
      look();
      tmss_panel_i.press('0, 1'b1);
      ctl = 5'h02;
      look();
      tmss_panel_i.set(8'h0f, 3'h1);
      tmss_panel_i.press(8'hf0, 1'b0);
      tsel = 8'ha5;
      look();
      patch = 32'h00fe_c650;
      wb(1'b1, REG_PATCH, patch, q, e);
      look();
      chk("altered lamp", altered_lamp_o, 1'b1);
      close_out();
   end
endmodule

/* sim/tmss_panel.sv */
// front panel and transport model feeding the monitor block
`timescale 1ns/1ps
module tmss_panel
(
   input  wire logic                                            clk_i,
   output logic      [tmss_pkg::TRACKS-1:0]                     track_arm_o,
   output logic      [tmss_pkg::TRACKS-1:0]                     sel_press_o,
   output logic                                                 ovr_press_o,
   output logic      [2:0]                                      xport_o,
   output logic      [tmss_pkg::TRACKS*tmss_pkg::SAMPLE_W-1:0]  src_o,
   output logic      [tmss_pkg::TRACKS*tmss_pkg::SAMPLE_W-1:0]  tape_o
);
   import tmss_pkg::*;
   initial
   begin
      track_arm_o = '0;
      sel_press_o = '0;
      ovr_press_o = 1'b0;
      xport_o     = 3'h0;
   end
   // arming and transport change just after an edge
   task automatic set(input logic [TRACKS-1:0] a, input logic [2:0] x);
      @(posedge clk_i);
      track_arm_o <= a;
      xport_o     <= x;
   endtask
   // one-cycle switch presses
   task automatic press(input logic [TRACKS-1:0] t, input logic o);
      @(posedge clk_i);
      sel_press_o <= t;
      ovr_press_o <= o;
      @(posedge clk_i);
      sel_press_o <= '0;
      ovr_press_o <= 1'b0;
   endtask
   // off-tape data is garbage while the tape stands still
   always_comb
   begin
      for (int t = 0; t < TRACKS; t++)
      begin
         src_o[t*SAMPLE_W+:SAMPLE_W]  = 24'h40_0000 | 24'(t * 273);
         tape_o[t*SAMPLE_W+:SAMPLE_W] = (24'h80_0000 | 24'(t * 546))
                                        ^ ((xport_o == 3'h0 || xport_o > 3'h3) ? 24'hff_ffff : 24'h00_0000);
      end
   end
endmodule
